// ---- src/mec_core.sv ----
// Query checker, exception reply builder and CRC-16 engine for the serial slave.
`timescale 1ns/1ps

module mec_core #(
  parameter int REG_MAX = mec_pkg::REG_MAX_DEF,
  parameter int COIL_MAX = mec_pkg::COIL_MAX_DEF
) (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Own station number
  input wire logic [7:0] i_station,
  // Received query bytes
  input wire logic i_rx_valid,
  input wire mec_pkg::mec_byte_type i_rx,
  output logic o_rx_ready,
  // Address map answers for o_map_addr; o_map_waddr has no answer
  output logic [15:0] o_map_addr,
  output logic [15:0] o_map_waddr,
  input wire logic i_map_reg_ok,
  input wire logic i_map_reg_wr_ok,
  input wire logic i_map_coil_ok,
  input wire logic i_map_coil_wr_ok,
  input wire logic i_value_ok,
  // Outcome of the check
  output logic o_accept,
  output logic o_drop,
  output mec_pkg::mec_query_type o_query,
  // Reply bytes
  output logic o_tx_valid,
  output mec_pkg::mec_byte_type o_tx,
  input wire logic i_tx_ready
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    mec_pkg::mec_state_type st;
    logic [3:0] idx;
    logic [15:0] crc;
    logic [7:0] station;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] waddr;
    logic [15:0] wqty;
    logic [7:0] bcnt;
    logic [7:0] rw_bcnt;
    logic [7:0] exc;
    logic [2:0] tx_idx;
    logic [15:0] tx_crc;
    logic [1:0][8:0] fifo;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
    logic accept;
    logic drop;
  } mec_core_type;

  mec_core_type r_reg;
  mec_core_type r_next;

  logic rx_fire;
  logic tx_fire;
  logic push;
  logic [7:0] push_byte;
  logic [7:0] exc_calc;
  logic fc_known;
  logic is_reg;
  logic is_coil;
  logic [15:0] coil_bytes;

  assign o_rx_ready = (r_reg.st == mec_pkg::ST_RECV);
  assign rx_fire = i_rx_valid && o_rx_ready && i_clk_en;
  assign o_tx_valid = (r_reg.cnt != 2'd0);
  assign o_tx = r_reg.fifo[r_reg.rd_ptr];
  assign tx_fire = o_tx_valid && i_tx_ready && i_clk_en;
  // Back-pressure: the reply stalls while both buffer entries are taken.
  assign push = (r_reg.st == mec_pkg::ST_SEND) && (r_reg.cnt != 2'd2) && i_clk_en;
  assign o_map_addr = r_reg.addr;
  assign o_map_waddr = r_reg.waddr;
  assign o_accept = r_reg.accept;
  assign o_drop = r_reg.drop;
  assign o_query = '{fc: r_reg.fc, addr: r_reg.addr, qty: r_reg.qty};

  // ****************************************************************
  // Query checks
  // ****************************************************************
  always_comb
  begin
    fc_known = (r_reg.fc == mec_pkg::FC_READ_COILS) || (r_reg.fc == mec_pkg::FC_READ_REGS) ||
      (r_reg.fc == mec_pkg::FC_WRITE_COIL) || (r_reg.fc == mec_pkg::FC_DIAG) ||
      (r_reg.fc == mec_pkg::FC_WRITE_COILS) || (r_reg.fc == mec_pkg::FC_WRITE_REGS) ||
      (r_reg.fc == mec_pkg::FC_READ_WRITE);
    is_reg = (r_reg.fc == mec_pkg::FC_READ_REGS) || (r_reg.fc == mec_pkg::FC_WRITE_REGS);
    is_coil = (r_reg.fc == mec_pkg::FC_READ_COILS) || (r_reg.fc == mec_pkg::FC_WRITE_COIL) ||
      (r_reg.fc == mec_pkg::FC_WRITE_COILS);
    coil_bytes = {3'b000, r_reg.qty[15:3]} + {15'h0000, (r_reg.qty[2:0] != 3'b000)};
    exc_calc = mec_pkg::EXC_NONE;
    if (!fc_known)
    begin
      exc_calc = mec_pkg::EXC_BAD_FC;
    end
    else if (is_reg)
    begin
      if (r_reg.addr[15:8] == mec_pkg::AREA_6000_HI &&
          ((r_reg.fc == mec_pkg::FC_READ_REGS && r_reg.addr > mec_pkg::AREA_READ_LAST) ||
           (r_reg.fc == mec_pkg::FC_WRITE_REGS && r_reg.addr > mec_pkg::AREA_WRITE_LAST)))
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (!i_map_reg_ok)
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (r_reg.fc == mec_pkg::FC_WRITE_REGS && !i_map_reg_wr_ok)
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (r_reg.qty == 16'h0000 || r_reg.qty[0] || r_reg.qty > 16'(REG_MAX))
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
      else if (r_reg.fc == mec_pkg::FC_WRITE_REGS && {8'h00, r_reg.bcnt} != {r_reg.qty[14:0], 1'b0})
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
      else if (r_reg.fc == mec_pkg::FC_WRITE_REGS && !i_value_ok)
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
    end
    else if (is_coil)
    begin
      if (!i_map_coil_ok)
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (r_reg.fc != mec_pkg::FC_READ_COILS && !i_map_coil_wr_ok)
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (r_reg.fc == mec_pkg::FC_WRITE_COIL)
      begin
        // The single coil write carries a value where the others carry a count.
        if (r_reg.qty != mec_pkg::COIL_ON && r_reg.qty != mec_pkg::COIL_OFF)
        begin
          exc_calc = mec_pkg::EXC_BAD_DATA;
        end
      end
      else if (r_reg.qty == 16'h0000 || r_reg.qty > 16'(COIL_MAX))
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
      else if (r_reg.fc == mec_pkg::FC_WRITE_COILS && {8'h00, r_reg.bcnt} != coil_bytes)
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
    end
    else if (r_reg.fc == mec_pkg::FC_READ_WRITE)
    begin
      if (r_reg.waddr < mec_pkg::AREA_BASE || r_reg.waddr > mec_pkg::AREA_WRITE_LAST ||
          r_reg.addr < mec_pkg::AREA_BASE || r_reg.addr > mec_pkg::AREA_READ_LAST)
      begin
        exc_calc = mec_pkg::EXC_BAD_ADDR;
      end
      else if (r_reg.qty == 16'h0000 || r_reg.qty[0] || r_reg.wqty == 16'h0000 ||
               r_reg.wqty[0])
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
      else if (r_reg.qty > mec_pkg::RW_READ_MAX || r_reg.wqty > mec_pkg::RW_WRITE_MAX)
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
      else if ({8'h00, r_reg.rw_bcnt} != {r_reg.wqty[14:0], 1'b0})
      begin
        exc_calc = mec_pkg::EXC_BAD_DATA;
      end
    end
  end

  // ****************************************************************
  // Reply byte selection
  // ****************************************************************
  always_comb
  begin
    case (r_reg.tx_idx)
      3'd0: push_byte = r_reg.station;
      3'd1: push_byte = r_reg.fc | mec_pkg::FC_EXC_FLAG;
      3'd2: push_byte = r_reg.exc;
      3'd3: push_byte = r_reg.tx_crc[7:0];
      default: push_byte = r_reg.tx_crc[15:8];
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    r_next = r_reg;
    if (tx_fire)
    begin
      r_next.rd_ptr = ~r_reg.rd_ptr;
    end
    if (push)
    begin
      r_next.fifo[r_reg.wr_ptr] = {push_byte, r_reg.tx_idx == mec_pkg::TX_LAST};
      r_next.wr_ptr = ~r_reg.wr_ptr;
    end
    r_next.cnt = r_reg.cnt + 2'(push) - 2'(tx_fire);
    if (i_clk_en)
    begin
      r_next.accept = 1'b0;
      r_next.drop = 1'b0;
      case (r_reg.st)
        mec_pkg::ST_RECV:
        begin
          if (rx_fire)
          begin
            // Checking the residue over the whole frame, CRC bytes included, is
            // equivalent to comparing the CRC of the data bytes; it ends at zero.
            r_next.crc = mec_pkg::mec_crc_step(r_reg.crc, i_rx.data);
            if (r_reg.idx != 4'hF)
            begin
              r_next.idx = r_reg.idx + 4'h1;
            end
            case (r_reg.idx)
              mec_pkg::IX_STATION: r_next.station = i_rx.data;
              mec_pkg::IX_FC: r_next.fc = i_rx.data;
              mec_pkg::IX_ADDR_H: r_next.addr[15:8] = i_rx.data;
              mec_pkg::IX_ADDR_L: r_next.addr[7:0] = i_rx.data;
              mec_pkg::IX_QTY_H: r_next.qty[15:8] = i_rx.data;
              mec_pkg::IX_QTY_L: r_next.qty[7:0] = i_rx.data;
              mec_pkg::IX_WADDR_H:
              begin
                r_next.bcnt = i_rx.data;
                r_next.waddr[15:8] = i_rx.data;
              end
              mec_pkg::IX_WADDR_L: r_next.waddr[7:0] = i_rx.data;
              mec_pkg::IX_WQTY_H: r_next.wqty[15:8] = i_rx.data;
              mec_pkg::IX_WQTY_L: r_next.wqty[7:0] = i_rx.data;
              mec_pkg::IX_RW_BCNT: r_next.rw_bcnt = i_rx.data;
              default:
              begin
              end
            endcase
            if (i_rx.last)
            begin
              r_next.st = mec_pkg::ST_CHECK;
            end
          end
        end
        mec_pkg::ST_CHECK:
        begin
          r_next.idx = 4'h0;
          r_next.crc = mec_pkg::CRC_INIT;
          r_next.tx_idx = 3'd0;
          r_next.tx_crc = mec_pkg::CRC_INIT;
          r_next.exc = exc_calc;
          if (r_reg.crc != 16'h0000 || r_reg.idx < mec_pkg::IX_MIN_LEN ||
              r_reg.station != i_station)
          begin
            r_next.drop = 1'b1;
            r_next.st = mec_pkg::ST_RECV;
          end
          else if (exc_calc == mec_pkg::EXC_NONE)
          begin
            r_next.accept = 1'b1;
            r_next.st = mec_pkg::ST_RECV;
          end
          else
          begin
            r_next.st = mec_pkg::ST_SEND;
          end
        end
        default:
        begin
          if (push)
          begin
            r_next.tx_idx = r_reg.tx_idx + 3'd1;
            if (r_reg.tx_idx < 3'd3)
            begin
              r_next.tx_crc = mec_pkg::mec_crc_step(r_reg.tx_crc, push_byte);
            end
            if (r_reg.tx_idx == mec_pkg::TX_LAST)
            begin
              r_next.st = mec_pkg::ST_RECV;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_reg <= '{st: mec_pkg::ST_RECV, crc: mec_pkg::CRC_INIT, tx_crc: mec_pkg::CRC_INIT,
                 default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_push_at(int n);
    push && r_reg.tx_idx == 3'(n);
  endsequence

  sequence s_frame_end;
    rx_fire && i_rx.last;
  endsequence

  a_exc_fc_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_push_at(1) |-> push_byte[7] && push_byte[6:0] == r_reg.fc[6:0])
    else $error("exception function code lacks top bit");

  a_reply_station: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_push_at(0) |-> push_byte == i_station && r_reg.exc != mec_pkg::EXC_NONE)
    else $error("reply does not open with station number");

  a_crc_low_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_push_at(3) |=> r_reg.fifo[!r_reg.wr_ptr] == {r_reg.tx_crc[7:0], 1'b0})
    else $error("CRC low byte not sent fourth");

  a_crc_high_last: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_push_at(4) |=> r_reg.st == mec_pkg::ST_RECV &&
      r_reg.fifo[!r_reg.wr_ptr] == {r_reg.tx_crc[15:8], 1'b1})
    else $error("CRC high byte not last");

  a_frame_check: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frame_end ##1 i_clk_en |=> (r_reg.crc == mec_pkg::CRC_INIT && r_reg.idx == 4'h0))
    else $error("CRC not restarted after frame");

  a_bad_crc_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (r_reg.st == mec_pkg::ST_CHECK && i_clk_en && r_reg.crc != 16'h0000) |=>
      o_drop && !o_accept && r_reg.st == mec_pkg::ST_RECV)
    else $error("frame with bad CRC not dropped");

  a_bad_fc_code: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (r_reg.st == mec_pkg::ST_CHECK && i_clk_en && !fc_known) |=> r_reg.exc == mec_pkg::EXC_BAD_FC)
    else $error("unknown function code not flagged 01h");

  a_coil_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (r_reg.st == mec_pkg::ST_CHECK && i_clk_en && r_reg.fc == mec_pkg::FC_WRITE_COIL &&
     i_map_coil_ok && i_map_coil_wr_ok && r_reg.qty != mec_pkg::COIL_ON &&
     r_reg.qty != mec_pkg::COIL_OFF) |=> r_reg.exc == mec_pkg::EXC_BAD_DATA)
    else $error("bad single coil value not flagged 03h");

  a_rw_limits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (r_reg.st == mec_pkg::ST_CHECK && i_clk_en && r_reg.fc == mec_pkg::FC_READ_WRITE &&
     r_reg.waddr > mec_pkg::AREA_WRITE_LAST) |=> r_reg.exc == mec_pkg::EXC_BAD_ADDR)
    else $error("17h write address outside area not flagged 02h");

  a_buffer_bound: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.cnt == 2'd2 |-> !push ##1 r_reg.cnt != 2'd3)
    else $error("reply buffer overfilled");

endmodule

// ---- src/mec_pkg.sv ----
// Package holding constants, types and the CRC step for the exception and CRC block.
package mec_pkg;

  // ****************************************************************
  // Codes and limits
  // ****************************************************************
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_REGS = 8'h03;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FC_WRITE_REGS = 8'h10;
  localparam logic [7:0] FC_READ_WRITE = 8'h17;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_FC = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  localparam logic [7:0] AREA_6000_HI = 8'h60;
  localparam logic [15:0] AREA_BASE = 16'h6000;
  localparam logic [15:0] AREA_READ_LAST = 16'h600F;
  localparam logic [15:0] AREA_WRITE_LAST = 16'h6007;
  localparam logic [15:0] RW_READ_MAX = 16'h0010;
  localparam logic [15:0] RW_WRITE_MAX = 16'h0008;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam int REG_MAX_DEF = 16;
  localparam int COIL_MAX_DEF = 16;

  // ****************************************************************
  // CRC-16
  // ****************************************************************
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ****************************************************************
  // Frame layout (byte index within the query)
  // ****************************************************************
  localparam logic [3:0] IX_STATION = 4'h0;
  localparam logic [3:0] IX_FC = 4'h1;
  localparam logic [3:0] IX_ADDR_H = 4'h2;
  localparam logic [3:0] IX_ADDR_L = 4'h3;
  localparam logic [3:0] IX_QTY_H = 4'h4;
  localparam logic [3:0] IX_QTY_L = 4'h5;
  localparam logic [3:0] IX_BCNT = 4'h6;
  localparam logic [3:0] IX_WADDR_H = 4'h6;
  localparam logic [3:0] IX_WADDR_L = 4'h7;
  localparam logic [3:0] IX_WQTY_H = 4'h8;
  localparam logic [3:0] IX_WQTY_L = 4'h9;
  localparam logic [3:0] IX_RW_BCNT = 4'hA;
  localparam logic [3:0] IX_MIN_LEN = 4'h4;
  localparam logic [2:0] TX_LAST = 3'h4;

  typedef enum {ST_RECV, ST_CHECK, ST_SEND} mec_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mec_byte_type;

  typedef struct packed {
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
  } mec_query_type;

  function automatic logic [15:0] mec_crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] t;
    t = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      t = t[0] ? ((t >> 1) ^ CRC_POLY) : (t >> 1);
    end
    return t;
  endfunction

endpackage

// ---- verification/mec_master.sv ----
// Serial master model that sends queries to the slave and collects its replies.
`timescale 1ns/1ps

module mec_master (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Receiver stall request
  input wire logic i_stall,
  // Query bytes
  output logic o_rx_valid,
  output mec_pkg::mec_byte_type o_rx,
  input wire logic i_rx_ready,
  // Reply bytes
  input wire logic i_tx_valid,
  input wire mec_pkg::mec_byte_type i_tx,
  output logic o_tx_ready
);
  mec_pkg::mec_byte_type out_q[$];
  mec_pkg::mec_byte_type reply_q[$];
  logic took = 1'b0;

  initial
  begin
    o_rx_valid = 1'b0;
    o_rx = '0;
    o_tx_ready = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
      begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // A corrupted check word flips one bit so the frame must be discarded.
  task automatic send(input logic [7:0] b[$], input bit bad);
    logic [15:0] c;
    c = crc16(b) ^ (bad ? 16'h0100 : 16'h0000);
    foreach (b[i])
    begin
      out_q.push_back({b[i], 1'b0});
    end
    out_q.push_back({c[7:0], 1'b0});
    out_q.push_back({c[15:8], 1'b1});
  endtask

  always @(posedge i_sys_clk)
  begin
    took <= o_rx_valid & i_rx_ready & i_clk_en & i_rst_n;
    if (i_rst_n && i_tx_valid && o_tx_ready && i_clk_en)
      reply_q.push_back(i_tx);
  end

  // An idle line inverts every bit each cycle, so it shows the last byte sent every other cycle.
  always @(negedge i_sys_clk)
  begin
    o_tx_ready <= ~i_stall;
    if (took)
      void'(out_q.pop_front());
    if (out_q.size() > 0)
    begin
      o_rx_valid <= 1'b1;
      o_rx <= out_q[0];
    end
    else
    begin
      o_rx_valid <= 1'b0;
      o_rx <= mec_pkg::mec_byte_type'(~o_rx);
    end
  end
endmodule

// ---- verification/mec_core_test.sv ----
// Self-checking bench for the exception reply and CRC block.
`timescale 1ns/1ps

module mec_core_test;
  typedef logic [7:0] mec_bytes_type[$];
  localparam int MAX_N = 16;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_stall = 1'b0;
  logic [7:0] station = 8'h01;
  logic val_ok = 1'b1;
  logic reg_ok_q = 1'b0;
  logic reg_wr_q = 1'b0;
  logic coil_ok_q = 1'b0;
  logic coil_wr_q = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, accept, drop;
  logic [15:0] map_addr;
  logic [15:0] map_waddr;
  mec_pkg::mec_byte_type rx, tx;
  mec_pkg::mec_query_type query;
  logic [31:0] seed_a = 32'hD41D9F18;
  logic [31:0] seed_b = 32'hD41D9F18;
  logic [7:0] fcs[9] = '{8'h01, 8'h03, 8'h05, 8'h08, 8'h0F, 8'h10, 8'h17, 8'h03, 8'h2B};
  logic [15:0] adr[9] = '{16'h4010, 16'h4070, 16'h5000, 16'h6007, 16'h6008, 16'h600F,
    16'h0005, 16'h0030, 16'h0050};
  int failures = 0;
  int total_checks = 0;
  int acc_n = 0;
  int drop_n = 0;

  mec_core #(.REG_MAX(MAX_N), .COIL_MAX(MAX_N)) uut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_station(station),
    .i_rx_valid(rx_valid), .i_rx(rx), .o_rx_ready(rx_ready),
    .o_map_addr(map_addr), .o_map_waddr(map_waddr), .i_map_reg_ok(reg_ok_q),
    .i_map_reg_wr_ok(reg_wr_q), .i_map_coil_ok(coil_ok_q), .i_map_coil_wr_ok(coil_wr_q),
    .i_value_ok(val_ok), .o_accept(accept), .o_drop(drop), .o_query(query),
    .o_tx_valid(tx_valid), .o_tx(tx), .i_tx_ready(tx_ready));

  mec_master master (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_stall(i_stall),
    .o_rx_valid(rx_valid), .o_rx(rx), .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx(tx), .o_tx_ready(tx_ready));

  // ****************************************************************
  // Reference functions
  // ****************************************************************
  function automatic logic [31:0] xs(ref logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic bit reg_ok(input logic [15:0] a);
    return a[15:8] == 8'h40 || (a >= 16'h6000 && a <= 16'h600F);
  endfunction

  function automatic bit reg_wr(input logic [15:0] a);
    return reg_ok(a) && !(a[15:8] == 8'h40 && a[7:0] >= 8'h60);
  endfunction

  function automatic mec_bytes_type build(input logic [7:0] fc, input logic [15:0] a, q,
    input logic [15:0] wa, wq, input logic [7:0] bc);
    mec_bytes_type f;
    f = '{station, fc, a[15:8], a[7:0], q[15:8], q[7:0]};
    if (fc == 8'h17)
      f = {f, wa[15:8], wa[7:0], wq[15:8], wq[7:0]};
    if (fc == 8'h0F || fc == 8'h10 || fc == 8'h17)
    begin
      f.push_back(bc);
      for (int i = 0; i < bc; i++)
        f.push_back(8'(xs(seed_a)));
    end
    return f;
  endfunction

  // Returns 00h for a query that is accepted.
  function automatic logic [7:0] exp_code(input mec_bytes_type f);
    logic [15:0] a;
    logic [15:0] q;
    logic [15:0] w;
    a = {f[2], f[3]};
    q = {f[4], f[5]};
    case (f[1])
      8'h01, 8'h05, 8'h0F:
      begin
        if (a >= 16'h0040 || (f[1] != 8'h01 && a >= 16'h0020))
          return 8'h02;
        if (f[1] == 8'h05)
          return (q == 16'hFF00 || q == 16'h0000) ? 8'h00 : 8'h03;
        if (q == 0 || q > MAX_N || (f[1] == 8'h0F && f[6] != 8'((q + 7) / 8)))
          return 8'h03;
      end
      8'h03, 8'h10:
      begin
        if (a[15:8] == 8'h60 && a > (f[1] == 8'h03 ? 16'h600F : 16'h6007))
          return 8'h02;
        if (!reg_ok(a) || (f[1] == 8'h10 && !reg_wr(a)))
          return 8'h02;
        if (q == 0 || q[0] || q > MAX_N)
          return 8'h03;
        if (f[1] == 8'h10 && (f[6] != 8'(2 * q) || !val_ok))
          return 8'h03;
      end
      8'h17:
      begin
        w = {f[8], f[9]};
        if (a < 16'h6000 || a > 16'h600F || {f[6], f[7]} < 16'h6000 || {f[6], f[7]} > 16'h6007)
          return 8'h02;
        if (q == 0 || q[0] || w == 0 || w[0] || q > 16 || w > 8)
          return 8'h03;
        if (f[10] != 8'(2 * w))
          return 8'h03;
      end
      8'h08:
        return 8'h00;
      default:
        return 8'h01;
    endcase
    return 8'h00;
  endfunction

  // ****************************************************************
  // Checks and run control
  // ****************************************************************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input string name, input mec_bytes_type f, input bit bad);
    logic [7:0] code;
    logic [15:0] c;
    int a0;
    int d0;
    code = (bad || f[0] != station) ? 8'hFF : exp_code(f);
    c = master.crc16('{f[0], f[1] | 8'h80, code});
    a0 = acc_n;
    d0 = drop_n;
    master.reply_q.delete();
    master.send(f, bad);
    for (int i = 0; i < 600; i++)
    begin
      @(negedge i_sys_clk);
      if (acc_n != a0 || drop_n != d0 || master.reply_q.size() >= 5)
        break;
    end
    repeat (12) @(negedge i_sys_clk);
    cmp_count(acc_n - a0, int'(code == 8'h00));
    cmp_count(drop_n - d0, int'(code == 8'hFF));
    if (code == 8'h00)
      cmp_byte(query.fc, f[1]);
    if (code == 8'h00)
      cmp_byte(query.qty[7:0], f[5]);
    cmp_byte(map_addr[7:0], f[3]);
    if (f[1] == 8'h17)
      cmp_byte(map_waddr[7:0], f[7]);
    cmp_count(master.reply_q.size(), (code == 8'h00 || code == 8'hFF) ? 0 : 5);
    if (code != 8'h00 && code != 8'hFF && master.reply_q.size() == 5)
    begin
      cmp_byte(master.reply_q[0].data, f[0]);
      cmp_byte(master.reply_q[1].data, f[1] | 8'h80);
      cmp_byte(master.reply_q[2].data, code);
      cmp_byte(master.reply_q[3].data, c[7:0]);
      cmp_byte(master.reply_q[4].data, c[15:8]);
      cmp_byte({7'h00, master.reply_q[4].last}, 8'h01);
    end
    $display("test %s done", name);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk)
  begin
    acc_n <= acc_n + int'(accept & i_clk_en);
    drop_n <= drop_n + int'(drop & i_clk_en);
  end

  always @(negedge i_sys_clk)
  begin
    i_clk_en <= xs(seed_b) % 8 != 0;
    i_stall <= xs(seed_b) % 3 == 0;
    reg_ok_q <= reg_ok(map_addr);
    reg_wr_q <= reg_wr(map_addr);
    coil_ok_q <= map_addr < 16'h0040;
    coil_wr_q <= map_addr < 16'h0020;
  end

  initial
  begin
    #800000;
    failures++;
    wrap_up();
  end

  initial
  begin
    mec_bytes_type f;
    logic [7:0] fc;
    logic [15:0] a;
    logic [15:0] q;
    logic [15:0] wq;
    repeat (5) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    f = '{8'h01, 8'h03, 8'h40, 8'h28, 8'h00, 8'h0E};
    cmp_count(int'(master.crc16(f)), 32'h0000C651);
    run("reference read", f, 1'b0);
    cmp_byte(query.addr[7:0], 8'h28);
    run("bad check word", f, 1'b1);
    f[0] = 8'h02;
    run("other station", f, 1'b0);
    for (int i = 0; i < 32; i++)
    begin
      fc = 8'(i);
      if (!(fc inside {8'h01, 8'h03, 8'h05, 8'h08, 8'h0F, 8'h10, 8'h17}))
        run("unsupported code", build(fc, 16'h4010, 16'h0002, 16'h0, 16'h0, 8'h0), 1'b0);
    end
    run("rw edges", build(8'h17, 16'h600F, 16'h0010, 16'h6007, 16'h0008, 8'h10), 1'b0);
    run("rw write addr", build(8'h17, 16'h6000, 16'h0002, 16'h6008, 16'h0002, 8'h04), 1'b0);
    run("rw read qty", build(8'h17, 16'h6000, 16'h0012, 16'h6000, 16'h0002, 8'h04), 1'b0);
    run("rw bytes", build(8'h17, 16'h6000, 16'h0002, 16'h6000, 16'h0002, 8'h03), 1'b0);
    run("coil value", build(8'h05, 16'h0005, 16'hFF01, 16'h0, 16'h0, 8'h0), 1'b0);
    val_ok = 1'b0;
    run("write range", build(8'h10, 16'h4010, 16'h0002, 16'h0, 16'h0, 8'h04), 1'b0);
    for (int n = 0; n < 250; n++)
    begin
      fc = fcs[xs(seed_a) % 9];
      a = adr[xs(seed_a) % 9];
      q = 16'(xs(seed_a) % 20);
      wq = 16'(xs(seed_a) % 12);
      if (fc == 8'h05 && xs(seed_a) % 3 != 0)
        q = xs(seed_a) % 2 ? 16'hFF00 : 16'h0000;
      val_ok = xs(seed_a) % 4 != 0;
      f = build(fc, a, q, adr[xs(seed_a) % 9], wq, 8'((fc == 8'h0F ? (q + 7) / 8 :
        fc == 8'h10 ? 2 * q : 2 * wq) + (xs(seed_a) % 5 == 0)));
      if (xs(seed_a) % 16 == 0)
        f[0] = 8'h07;
      run("random", f, xs(seed_a) % 16 == 0);
    end
    wrap_up();
  end
endmodule
